// *** src/cmc_controller.sv ***
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "cmc_map.svh"
module cmc_controller
#(
   parameter int CENTERS = 15
)
(
   input  wire logic               clock_i,
   input  wire logic               rst_i,
   input  wire logic [7:0]         addr_i,
   input  wire logic [15:0]        wdata_i,
   input  wire logic               we_i,
   input  wire logic               re_i,
   output logic [15:0]             rdata_o,
   input  wire cmc_pkg::cmc_frame_s rx_frame_i,
   input  wire logic               rx_valid_i,
   output logic                    rx_ready_o,
   output cmc_pkg::cmc_frame_s     tx_frame_o,
   output logic                    tx_valid_o,
   input  wire logic               tx_ready_i,
   input  wire logic               err_i,
   output logic [15:0]             bit_timing_o,
   output logic                    irq_o
);
   // ============================================================
   // Parameter check
   if (CENTERS != 15)
   begin : g_bad
      $error("cmc_controller serves exactly fifteen centers");
   end

   // ============================================================
   // State
   cmc_pkg::cmc_state_e  st_q;
   cmc_pkg::cmc_frame_s  rx_q;
   cmc_pkg::cmc_ctl_s    ctl_q [1:15];
   logic [15:0]          mem [0:127];
   logic [3:0]           k_q;
   logic [2:0]           widx_q;
   logic [6:0]           ptr_q;
   logic                 enable_q;
   logic [7:0]           errcnt_q;
   logic [14:0]          newdata_q;
   logic [3:0]           source_q;
   logic [7:0]           media_lo_q;
   logic [7:0]           media_hi_q;
   logic [15:0]          media_mask_q;
   logic [15:0]          int_stat_q;
   logic [15:0]          int_en_q;
   logic [15:0]          ev;
   logic                 wr_buf;
   logic                 cpu_mem_we;
   logic [6:0]           store_addr;
   logic [15:0]          store_word;
   logic                 store_done;
   logic                 send_done;

   // ============================================================
   // Match logic for the center under scan
   cmc_pkg::cmc_ctl_s c;
   logic [28:0] idw;
   logic [28:0] idcare;
   logic [15:0] mcare;
   logic        id_ok;
   logic        media_ok;
   logic        hit_rx;
   logic        hit_tx;
   always_comb
   begin
      c = ctl_q[k_q];
      idw = {mem[{k_q, `CMC_W_ID_HI}][12:0], mem[{k_q, `CMC_W_ID_LO}]};
      // Mask word pair lives in the unused center zero slots
      idcare = c.use_mask ? ~{mem[1][12:0], mem[0]} : '1;
      if (!c.ext)
      begin
         idcare[28:11] = '0;
      end
      mcare = c.use_mask ? ~media_mask_q : 16'hFFFF;
      id_ok = ((idw ^ rx_q.id) & idcare) == 29'h0 && c.ext == rx_q.ext;
      media_ok = ((rx_q.data[15:0] ^ {media_hi_q, media_lo_q}) & mcare) == 16'h0;
      if (k_q == 4'hF)
      begin
         hit_rx = !rx_q.rtr;
         hit_tx = 1'b0;
      end
      else
      begin
         hit_rx = !c.dir && !rx_q.rtr && id_ok && media_ok;
         hit_tx = rx_q.rtr && c.dir && !c.transmit_inhibit && c.data_updated
                  && c.center_ready && c.transmit_request && c.auto_remote && id_ok;
      end
   end

   assign rx_ready_o = (st_q == cmc_pkg::CMC_IDLE) && enable_q;
   assign store_addr = {k_q, widx_q};
   assign store_done = (st_q == cmc_pkg::CMC_STORE) && widx_q == `CMC_W_LAST;
   assign send_done  = tx_valid_o && tx_ready_i;

   always_comb
   begin
      case (widx_q)
         3'h0:    store_word = rx_q.id[15:0];
         3'h1:    store_word = {3'h0, rx_q.id[28:16]};
         3'h2:    store_word = rx_q.data[15:0];
         3'h3:    store_word = rx_q.data[31:16];
         3'h4:    store_word = rx_q.data[47:32];
         default: store_word = rx_q.data[63:48];
      endcase
   end

   // ============================================================
   // Engine
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_q <= cmc_pkg::CMC_IDLE;
         rx_q <= '0;
         k_q <= 4'h1;
         widx_q <= 3'h0;
         tx_frame_o <= '0;
         tx_valid_o <= 1'b0;
      end
      else
      begin
         case (st_q)
            cmc_pkg::CMC_IDLE:
            begin
               if (rx_valid_i && rx_ready_o)
               begin
                  rx_q <= rx_frame_i;
                  k_q <= 4'h1;
                  st_q <= cmc_pkg::CMC_SCAN;
               end
            end
            cmc_pkg::CMC_SCAN:
            begin
               // Ascending scan, first hit wins
               if (hit_tx)
               begin
                  tx_frame_o <= {idw, c.ext, 1'b0, c.dlc, mem[{k_q, 3'h5}],
                                 mem[{k_q, 3'h4}], mem[{k_q, 3'h3}], mem[{k_q, 3'h2}]};
                  tx_valid_o <= 1'b1;
                  st_q <= cmc_pkg::CMC_SEND;
               end
               else if (hit_rx)
               begin
                  widx_q <= 3'h0;
                  st_q <= cmc_pkg::CMC_STORE;
               end
               else if (k_q == 4'hF)
               begin
                  st_q <= cmc_pkg::CMC_IDLE;
               end
               else
               begin
                  k_q <= k_q + 4'h1;
               end
            end
            cmc_pkg::CMC_STORE:
            begin
               widx_q <= widx_q + 3'h1;
               if (store_done)
               begin
                  st_q <= cmc_pkg::CMC_IDLE;
               end
            end
            cmc_pkg::CMC_SEND:
            begin
               if (send_done)
               begin
                  tx_valid_o <= 1'b0;
                  st_q <= cmc_pkg::CMC_IDLE;
               end
            end
            default:
            begin
               st_q <= cmc_pkg::CMC_IDLE;
            end
         endcase
      end
   end

   // ============================================================
   // Shared memory
   // Engine owns the center it is storing; a clashing buffer write is dropped
   assign wr_buf = we_i && addr_i == `CMC_A_BUFFER;
   assign cpu_mem_we = wr_buf && !((st_q == cmc_pkg::CMC_STORE) && ptr_q[6:3] == k_q);
   always_ff @(posedge clock_i)
   begin
      if (st_q == cmc_pkg::CMC_STORE)
      begin
         mem[store_addr] <= store_word;
      end
      if (cpu_mem_we)
      begin
         mem[ptr_q] <= wdata_i;
      end
   end

   // ============================================================
   // Per center controls
   for (genvar n = 1; n <= 15; n++)
   begin : g_ctl
      always_ff @(posedge clock_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            ctl_q[n] <= '0;
         end
         else
         begin
            if (we_i && addr_i == {`CMC_A_CCTL_BASE, 4'(n)})
            begin
               ctl_q[n] <= cmc_pkg::cmc_ctl_s'(wdata_i[`CMC_CTL_BITS-1:0]);
               if (n == 15)
               begin
                  ctl_q[n].dir <= 1'b0;
               end
            end
            if (store_done && k_q == 4'(n))
            begin
               ctl_q[n].data_updated <= 1'b1;
               ctl_q[n].dlc <= rx_q.dlc;
            end
         end
      end
      assign ev[n-1] = ((store_done || send_done) && k_q == 4'(n)) && ctl_q[n].int_en;
   end
   assign ev[`CMC_ERR_BIT] = err_i;

   // ============================================================
   // Global registers
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         enable_q <= 1'b0;
         bit_timing_o <= 16'h0000;
         media_lo_q <= 8'h00;
         media_hi_q <= 8'h00;
         media_mask_q <= 16'h0000;
         ptr_q <= 7'h00;
         int_en_q <= 16'h0000;
      end
      else if (we_i)
      begin
         case (addr_i)
            `CMC_A_CTRL:       enable_q <= wdata_i[0];
            `CMC_A_BITTIME:    bit_timing_o <= wdata_i;
            `CMC_A_MEDIA_LO:   media_lo_q <= wdata_i[7:0];
            `CMC_A_MEDIA_HI:   media_hi_q <= wdata_i[7:0];
            `CMC_A_MEDIA_MASK: media_mask_q <= wdata_i;
            `CMC_A_POINTER:    ptr_q <= wdata_i[6:0];
            `CMC_A_BUFFER:     ptr_q <= ptr_q + 7'h01;
            `CMC_A_INT_EN:     int_en_q <= wdata_i;
            default:           ptr_q <= ptr_q;
         endcase
      end
      else if (re_i && addr_i == `CMC_A_BUFFER)
      begin
         ptr_q <= ptr_q + 7'h01;
      end
   end

   // Status flags: a set in the clearing cycle survives
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         errcnt_q <= 8'h00;
         newdata_q <= 15'h0000;
         source_q <= 4'h0;
         int_stat_q <= 16'h0000;
      end
      else
      begin
         if (err_i && errcnt_q != 8'hFF)
         begin
            errcnt_q <= errcnt_q + 8'h01;
         end
         else if (we_i && addr_i == `CMC_A_ERRCNT)
         begin
            errcnt_q <= 8'h00;
         end
         newdata_q <= (newdata_q & ~((we_i && addr_i == `CMC_A_NEWDATA) ? wdata_i[14:0] : 15'h0000))
                      | (store_done ? 15'(15'h0001 << (k_q - 4'h1)) : 15'h0000);
         if (store_done || send_done)
         begin
            source_q <= k_q;
         end
         int_stat_q <= (int_stat_q & ~((we_i && addr_i == `CMC_A_INT_CLR) ? wdata_i : 16'h0000))
                       | ev;
      end
   end
   assign irq_o = |(int_stat_q & int_en_q);

   // ============================================================
   // Read port
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_o <= 16'h0000;
      end
      else if (re_i)
      begin
         case (addr_i)
            `CMC_A_CTRL:       rdata_o <= {15'h0000, enable_q};
            `CMC_A_ERRCNT:     rdata_o <= {8'h00, errcnt_q};
            `CMC_A_NEWDATA:    rdata_o <= {1'b0, newdata_q};
            `CMC_A_SOURCE:     rdata_o <= {12'h000, source_q};
            `CMC_A_BITTIME:    rdata_o <= bit_timing_o;
            `CMC_A_MEDIA_LO:   rdata_o <= {8'h00, media_lo_q};
            `CMC_A_MEDIA_HI:   rdata_o <= {8'h00, media_hi_q};
            `CMC_A_MEDIA_MASK: rdata_o <= media_mask_q;
            `CMC_A_POINTER:    rdata_o <= {9'h000, ptr_q};
            `CMC_A_BUFFER:     rdata_o <= mem[ptr_q];
            `CMC_A_INT_STAT:   rdata_o <= int_stat_q;
            `CMC_A_INT_EN:     rdata_o <= int_en_q;
            default:
            begin
               if (addr_i[7:4] == `CMC_A_CCTL_BASE && addr_i[3:0] != 4'h0)
               begin
                  rdata_o <= {3'h0, ctl_q[addr_i[3:0]]};
               end
               else
               begin
                  rdata_o <= 16'h0000;
               end
            end
         endcase
      end
      else
      begin
         rdata_o <= 16'h0000;
      end
   end

   // ============================================================
   // Checks
   property p_store_flag;
      @(posedge clock_i) disable iff (rst_i)
      store_done |=> st_q == cmc_pkg::CMC_IDLE && newdata_q[$past(k_q) - 4'h1];
   endproperty
   a_store_flag: assert property (p_store_flag) else $error("store end wrong");
   property p_catch_all;
      @(posedge clock_i) disable iff (rst_i)
      (rx_valid_i && rx_ready_o && !rx_frame_i.rtr) |=> ##[0:15] st_q == cmc_pkg::CMC_STORE;
   endproperty
   a_catch_all: assert property (p_catch_all) else $error("data frame not stored");
   property p_tx_ready;
      @(posedge clock_i) disable iff (rst_i)
      $rose(tx_valid_o) |-> $past(ctl_q[k_q].dir && ctl_q[k_q].transmit_request
                                  && !ctl_q[k_q].transmit_inhibit && rx_q.rtr);
   endproperty
   a_tx_ready: assert property (p_tx_ready) else $error("send from unready center");
   property p_tx_hold;
      @(posedge clock_i) disable iff (rst_i)
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_frame_o);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("answer frame dropped");
   property p_no_corrupt;
      @(posedge clock_i) disable iff (rst_i)
      (st_q == cmc_pkg::CMC_STORE && wr_buf && ptr_q == store_addr)
      |=> mem[$past(store_addr)] == $past(store_word);
   endproperty
   a_no_corrupt: assert property (p_no_corrupt) else $error("store corrupted");
   property p_dir15;
      @(posedge clock_i) disable iff (rst_i)
      we_i && addr_i == 8'h1F |=> !ctl_q[15].dir;
   endproperty
   a_dir15: assert property (p_dir15) else $error("center fifteen transmits");
   property p_err_irq;
      @(posedge clock_i) disable iff (rst_i)
      err_i && int_en_q[15] && !we_i |=> int_stat_q[15] && irq_o;
   endproperty
   a_err_irq: assert property (p_err_irq) else $error("error not flagged");
   property p_buf_read;
      @(posedge clock_i) disable iff (rst_i)
      re_i && addr_i == `CMC_A_BUFFER |=> rdata_o == $past(mem[ptr_q]) && ptr_q == $past(ptr_q) + 7'h01;
   endproperty
   a_buf_read: assert property (p_buf_read) else $error("buffer read wrong");
   c_store: cover property (@(posedge clock_i) disable iff (rst_i) store_done);
   c_send: cover property (@(posedge clock_i) disable iff (rst_i) send_done);
   c_irq: cover property (@(posedge clock_i) disable iff (rst_i) $rose(irq_o));
endmodule

// *** src/cmc_map.svh ***
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH
// Contract
// - Fifteen centers, identifier plus eight data bytes
// - Per center standard or extended identifier
// - Centers one to fourteen: transmit or receive
// - Center fifteen receives everything else unaccepted (code: only data frames; an unanswered remote frame is dropped)
// - Accept only on masked identifier match
// - First two data bytes match media bytes
// - Global mask bits exclude compare positions
// - Transmit ready needs all five control conditions
// - Ready center answers matching remote frame
// - Controls in registers, contents in shared memory
// - Processor reaches memory via pointer and buffer
// - Global error, new data, timing, source registers
// - Per center direction, interrupt, format, length controls
// - Bus protocol handled to CAN 2.0B (code: frame-level ports only; no bus protocol logic)
// ============================================================
// Register indexes
`define CMC_A_CTRL       8'h00
`define CMC_A_ERRCNT     8'h01
`define CMC_A_NEWDATA    8'h02
`define CMC_A_SOURCE     8'h03
`define CMC_A_BITTIME    8'h04
`define CMC_A_MEDIA_LO   8'h05
`define CMC_A_MEDIA_HI   8'h06
`define CMC_A_MEDIA_MASK 8'h07
`define CMC_A_POINTER    8'h08
`define CMC_A_BUFFER     8'h09
`define CMC_A_INT_STAT   8'h0A
`define CMC_A_INT_CLR    8'h0B
`define CMC_A_INT_EN     8'h0C
`define CMC_A_CCTL_BASE  4'h1
// ============================================================
// Shared memory word slots inside a center, control register width and error interrupt bit
`define CMC_W_ID_LO      3'h0
`define CMC_W_ID_HI      3'h1
`define CMC_W_LAST       3'h5
`define CMC_CTL_BITS     13
`define CMC_ERR_BIT      15
`endif

// *** src/cmc_pkg.sv ***
package cmc_pkg;
   typedef struct packed {
      logic       dir;
      logic       transmit_inhibit;
      logic       data_updated;
      logic       center_ready;
      logic       transmit_request;
      logic       auto_remote;
      logic       int_en;
      logic       ext;
      logic       use_mask;
      logic [3:0] dlc;
   } cmc_ctl_s;
   typedef struct packed {
      logic [28:0] id;
      logic        ext;
      logic        rtr;
      logic [3:0]  dlc;
      logic [63:0] data;
   } cmc_frame_s;
   typedef enum logic [3:0] {
      CMC_IDLE  = 4'h1,
      CMC_SCAN  = 4'h2,
      CMC_STORE = 4'h4,
      CMC_SEND  = 4'h8
   } cmc_state_e;
endpackage

// *** bench/cmc_node_model.sv ***
`timescale 1ns/1ps
// ============================================================
// Far bus node seen at frame level
module cmc_node_model
(
   input  wire logic                clock_i,
   input  wire logic                rst_i,
   output cmc_pkg::cmc_frame_s      rx_frame_o,
   output logic                     rx_valid_o,
   input  wire logic                rx_ready_i,
   input  wire cmc_pkg::cmc_frame_s tx_frame_i,
   input  wire logic                tx_valid_i,
   output logic                     tx_ready_o
);
   int                  stall;
   int                  n_tx;
   int                  wait_q;
   cmc_pkg::cmc_frame_s last_tx;

   initial
   begin
      stall = 0;
      rx_valid_o = 1'b0;
      rx_frame_o = '0;
   end

   // ============================================================
   // Offer held until taken or 300 cycles pass, then scrambled so stale data never passes
   task automatic send(input cmc_pkg::cmc_frame_s f);
      int n;
      n = 0;
      @(posedge clock_i);
      rx_frame_o <= f;
      rx_valid_o <= 1'b1;
      do
      begin
         @(posedge clock_i);
         n++;
      end
      while (rx_ready_i !== 1'b1 && n < 300);
      rx_valid_o <= 1'b0;
      rx_frame_o <= ~f;
   endtask

   // ============================================================
   // Answer acceptance, slowed by stall cycles
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tx_ready_o <= 1'b0;
         wait_q <= 0;
         n_tx <= 0;
      end
      else if (tx_valid_i && tx_ready_o)
      begin
         last_tx <= tx_frame_i;
         n_tx <= n_tx + 1;
         tx_ready_o <= 1'b0;
         wait_q <= 0;
      end
      else if (tx_valid_i)
      begin
         wait_q <= wait_q + 1;
         tx_ready_o <= (wait_q >= stall);
      end
   end
endmodule

// *** bench/cmc_controller_bench.sv ***
`timescale 1ns/1ps
`include "cmc_map.svh"
module cmc_controller_bench;
   typedef struct {logic [7:0] a; logic wr; logic [15:0] w; logic [15:0] e;} cmc_row_s;
   typedef struct {logic [28:0] id; logic ext; logic [15:0] lo; logic [3:0] src;} cmc_case_s;
   logic                clock_i;
   logic                rst_i;
   logic [7:0]          addr_i;
   logic [15:0]         wdata_i;
   logic                we_i;
   logic                re_i;
   logic [15:0]         rdata_o;
   cmc_pkg::cmc_frame_s rx_frame;
   logic                rx_valid;
   logic                rx_ready_o;
   cmc_pkg::cmc_frame_s tx_frame_o;
   logic                tx_valid_o;
   logic                tx_ready;
   logic                err_i;
   logic [15:0]         bit_timing_o;
   logic                irq_o;
   int                  n_mismatch;
   int                  num_checks;
   int                  cyc;
   cmc_row_s            rows[16];
   cmc_case_s           cases[6];

   cmc_controller #(.CENTERS(15)) u_dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .rx_frame_i(rx_frame),
      .rx_valid_i(rx_valid), .rx_ready_o(rx_ready_o), .tx_frame_o(tx_frame_o),
      .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready), .err_i(err_i),
      .bit_timing_o(bit_timing_o), .irq_o(irq_o));
   cmc_node_model u_node (.clock_i(clock_i), .rst_i(rst_i), .rx_frame_o(rx_frame),
      .rx_valid_o(rx_valid), .rx_ready_i(rx_ready_o), .tx_frame_i(tx_frame_o),
      .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready));

   // ============================================================
   // Clock and hang guard
   initial
   begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   always @(posedge clock_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         conclude();
      end
   end

   // ============================================================
   // Shared tasks
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      we_i <= 1'b1;
      @(posedge clock_i);
      we_i <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [15:0] e, input string n);
      @(posedge clock_i);
      addr_i <= a;
      re_i <= 1'b1;
      @(posedge clock_i);
      re_i <= 1'b0;
      @(negedge clock_i);
      chk(n, 64'(e), 64'(rdata_o));
   endtask
   // Pointer load then buffer accesses with auto-increment
   task automatic memw(input logic [3:0] c, input logic [15:0] w0, input logic [15:0] w1);
      wr(`CMC_A_POINTER, {9'h000, c, 3'h0});
      wr(`CMC_A_BUFFER, w0);
      wr(`CMC_A_BUFFER, w1);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do
      begin
         @(posedge clock_i);
         n++;
      end
      while (!(rx_ready_o === 1'b1 && tx_valid_o !== 1'b1) && n < 100);
      chk("idle", 64'h1, 64'(n < 100));
   endtask
   function automatic cmc_pkg::cmc_frame_s mk(input logic [28:0] id, input logic ext,
                                               input logic rtr, input logic [15:0] lo);
      mk = '{id: id, ext: ext, rtr: rtr, dlc: 4'h8, data: {48'hDDCC_5566_7788, lo}};
   endfunction

   // ============================================================
   // Main sequence
   initial
   begin
      rst_i = 1'b1;
      addr_i = 8'h00;
      wdata_i = 16'h0000;
      we_i = 1'b0;
      re_i = 1'b0;
      err_i = 1'b0;
      n_mismatch = 0;
      num_checks = 0;
      cyc = 0;
      rows = '{'{8'h01, 0, 0, 0}, '{8'h02, 0, 0, 0}, '{8'h0A, 0, 0, 0}, '{8'h0D, 0, 0, 0},
         '{8'h0A, 1, 16'hFFFF, 0}, '{8'h04, 1, 16'h1234, 16'h1234}, '{8'h05, 1, 16'h00AA, 16'h00AA},
         '{8'h06, 1, 16'h00BB, 16'h00BB}, '{8'h07, 1, 16'h00FF, 16'h00FF},
         '{8'h0C, 1, 16'h801F, 16'h801F},
         '{8'h1F, 1, 16'h1000, 0}, '{8'h11, 1, 16'h0048, 16'h0048}, '{8'h12, 1, 16'h0048, 16'h0048},
         '{8'h13, 1, 16'h0058, 16'h0058}, '{8'h14, 1, 16'h0068, 16'h0068},
         '{8'h15, 1, 16'h17C8, 16'h17C8}};
      cases = '{'{29'h123, 0, 16'hBBAA, 1}, '{29'h305, 0, 16'hBBAA, 3},
         '{29'h1ABCDE12, 1, 16'hBBAA, 4}, '{29'h456, 0, 16'hBBAA, 15}, '{29'h123, 0, 0, 15},
         '{29'h30A, 0, 16'hBB00, 3}};
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      chk("rx_ready_off", 64'h0, 64'(rx_ready_o));
      for (int i = 0; i < 16; i++)
      begin
         if (rows[i].wr)
            wr(rows[i].a, rows[i].w);
         rdchk(rows[i].a, rows[i].e, "row");
      end
      chk("bit_timing", 64'h1234, 64'(bit_timing_o));
      for (int c = 1; c < 16; c++)
      begin
         memw(c[3:0], 16'h0700 | 16'(c), 16'h0000);
         repeat (4) wr(`CMC_A_BUFFER, 16'h0000);
      end
      memw(4'h0, 16'h000F, 16'h0000);
      memw(4'h1, 16'h0123, 16'h0000);
      memw(4'h2, 16'h0123, 16'h0000);
      memw(4'h3, 16'h0300, 16'h0000);
      memw(4'h4, 16'hDE12, 16'h1ABC);
      memw(4'h5, 16'h0055, 16'h0000);
      for (int k = 1; k < 5; k++)
         wr(`CMC_A_BUFFER, 16'h1111 * 16'(k));
      wr(`CMC_A_CTRL, 16'h0001);
      // Acceptance cases: exact, masked, extended, catch-all, media mismatch, media masked
      foreach (cases[i])
      begin
         u_node.send(mk(cases[i].id, cases[i].ext, 1'b0, cases[i].lo));
         wait_idle();
         rdchk(`CMC_A_NEWDATA, 16'h0001 << (cases[i].src - 4'h1), "newdata");
         rdchk(`CMC_A_SOURCE, {12'h000, cases[i].src}, "source");
         chk("irq", 64'(cases[i].src != 4'hF), 64'(irq_o));
         wr(`CMC_A_NEWDATA, 16'hFFFF);
         wr(`CMC_A_INT_CLR, 16'hFFFF);
         @(negedge clock_i);
         chk("irq_clear", 64'h0, 64'(irq_o));
      end
      rdchk(`CMC_A_NEWDATA, 16'h0000, "newdata_clr");
      wr(`CMC_A_POINTER, 16'h000A);
      rdchk(`CMC_A_BUFFER, 16'hBBAA, "c1_w2");
      rdchk(`CMC_A_BUFFER, 16'h7788, "c1_w3");
      rdchk(`CMC_A_BUFFER, 16'h5566, "c1_w4");
      rdchk(`CMC_A_BUFFER, 16'hDDCC, "c1_w5");
      wr(`CMC_A_POINTER, 16'h0012);
      rdchk(`CMC_A_BUFFER, 16'h0000, "c2_w2");
      rdchk(8'h11, 16'h0448, "c1_ctl");
      // Remote frame answered while the far node stalls
      u_node.stall = 3;
      u_node.send(mk(29'h055, 1'b0, 1'b1, 16'hBBAA));
      wait_idle();
      chk("tx_count", 64'h1, 64'(u_node.n_tx));
      chk("tx_id", 64'h55, 64'(u_node.last_tx.id));
      chk("tx_data", 64'h4444_3333_2222_1111, u_node.last_tx.data);
      rdchk(`CMC_A_SOURCE, 16'h0005, "tx_source");
      rdchk(`CMC_A_INT_STAT, 16'h0010, "tx_int");
      wr(`CMC_A_INT_CLR, 16'hFFFF);
      // Inhibited center stays silent and the remote frame is dropped
      wr(8'h15, 16'h1FC8);
      u_node.send(mk(29'h055, 1'b0, 1'b1, 16'hBBAA));
      wait_idle();
      chk("tx_inhibit", 64'h1, 64'(u_node.n_tx));
      rdchk(`CMC_A_NEWDATA, 16'h0000, "rtr_drop");
      // Two bus errors, then clear
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clock_i);
         err_i <= 1'b1;
         @(posedge clock_i);
         err_i <= 1'b0;
      end
      rdchk(`CMC_A_ERRCNT, 16'h0002, "errcnt");
      rdchk(`CMC_A_INT_STAT, 16'h8000, "err_int");
      chk("err_irq", 64'h1, 64'(irq_o));
      wr(`CMC_A_ERRCNT, 16'h0000);
      rdchk(`CMC_A_ERRCNT, 16'h0000, "errcnt_clr");
      // Buffer write into the center being stored is dropped, pointer still steps
      wr(`CMC_A_POINTER, 16'h0008);
      u_node.send(mk(29'h123, 1'b0, 1'b0, 16'hBBAA));
      wr(`CMC_A_BUFFER, 16'hFFFF);
      wait_idle();
      rdchk(`CMC_A_POINTER, 16'h0009, "guard_ptr");
      wr(`CMC_A_POINTER, 16'h0008);
      rdchk(`CMC_A_BUFFER, 16'h0123, "store_guard");
      // Reset in mid-run clears outputs and enable
      @(posedge clock_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      chk("rst_out", 64'h0, 64'({tx_valid_o, rx_ready_o, irq_o, bit_timing_o}));
      rst_i <= 1'b0;
      rdchk(`CMC_A_CTRL, 16'h0000, "ctrl_rst");
      conclude();
   end
endmodule
